// ---- hdl/tsr_defines.svh ----
// Purpose: Shared constants of the temperature sensor register and alert block.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Write field positions, limit and rate reset values and conversion periods live here only.
//
// Behaviour
// - Eight-bit pointer, only two low bits writable
// - Pointer picks temperature, setup, lower, upper register
// - Temperature is read-only; other three are read-write
// - Setup word moves most significant byte first
// - Setup bits 0-4,13 read zero; bit 14 one
// - Flag reads one until upper limit fault run
// - Polarity inverts the alert flag values
// - Comparator mode: flag mirrors the alert output
// - Rate field picks 0.25/1/4/8 conversions, reset 4
// - Temperature changes only when a conversion completes
// - Conversion starts immediately after power-on reset
// - Standby between conversions until rate timer fires
// - Setting sleep halts conversions at once, registers live
// - Sleep entry slow; first conversion after may lengthen
// - Clearing sleep resumes continuous conversions at rate
// - Latch mode bit: zero comparator, one event
// - Comparator alert holds from upper until lower crossing
// - Event alert changes on either limit crossing
// - Polarity bit: zero active low, one active high
// - Fault field needs 1 to 4 consecutive conversions
// - One-shot in sleep: reads one while converting
// - Event alert cleared by any read or sleep
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

// ----------------------------------------------------------------
// Pointer codes and setup field positions
// ----------------------------------------------------------------
`define TSR_PTR_TEMP   2'h0
`define TSR_PTR_SETUP  2'h1
`define TSR_PTR_LOWER  2'h2
`define TSR_PTR_UPPER  2'h3
`define TSR_B_FLAG     5
`define TSR_B_RATE     7:6
`define TSR_B_SLEEP    8
`define TSR_B_LATCH    9
`define TSR_B_POL      10
`define TSR_B_FAULT    12:11
`define TSR_B_ONESHOT  15

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define TSR_RATE_RST   2'h2
`define TSR_LOWER_RST  16'h2580
`define TSR_UPPER_RST  16'h2800
`define TSR_LIM_ZERO   4'h0
`define TSR_RATE0_MS   4000
`define TSR_RATE1_MS   1000
`define TSR_RATE2_MS   250
`define TSR_RATE3_MS   125
`define TSR_CLK_KHZ    100000

`endif

// ---- hdl/tsr_pkg.sv ----
// Purpose: Types shared by the sensor register block and its scheduler.
// Assumes: Nothing beyond the defines header.
// Notes:   Constants stay in the header; only types live here.
package tsr_pkg;
  typedef enum logic [1:0] {CMD_PTR, CMD_WR, CMD_RD} tsr_cmd_t;
  typedef enum logic {CV_IDLE, CV_BUSY} tsr_conv_st_t;
endpackage

// ---- hdl/tsr_conv_sched.sv ----
// Purpose: Rate timer and converter handshake for the sensor block.
// Assumes: Converter sits on core_clk_in and pulses done while requested.
// Notes:   A done seen with no request pending is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_conv_sched
  import tsr_pkg::*;
#(
  parameter int PER0_CYC = `TSR_RATE0_MS * `TSR_CLK_KHZ,
  parameter int PER1_CYC = `TSR_RATE1_MS * `TSR_CLK_KHZ,
  parameter int PER2_CYC = `TSR_RATE2_MS * `TSR_CLK_KHZ,
  parameter int PER3_CYC = `TSR_RATE3_MS * `TSR_CLK_KHZ
) (
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        sleep_in,
  input  wire logic [1:0]  rate_in,
  input  wire logic        oneshot_in,
  input  wire logic        conv_done_in,
  input  wire logic [15:0] conv_data_in,
  output logic             conv_req_out,
  output logic             res_valid_out,
  output logic [15:0]      res_data_out,
  output logic             os_busy_out
);
  tsr_conv_st_t st;
  logic [31:0]  tmr;
  logic         sleep_q;

  // Period in cycles for a rate code.
  function automatic logic [31:0] period(input logic [1:0] r);
    unique case (r)
      2'h0: period = 32'(PER0_CYC);
      2'h1: period = 32'(PER1_CYC);
      2'h2: period = 32'(PER2_CYC);
      2'h3: period = 32'(PER3_CYC);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  // Reset lands in the busy state so the first conversion needs no host.
  always_ff @(posedge core_clk_in) begin
    res_valid_out <= 1'b0;
    sleep_q       <= sleep_in;
    if (!resetn_in) begin
      st           <= CV_BUSY;
      conv_req_out <= 1'b1;
      tmr          <= 32'h0000_0000;
      os_busy_out  <= 1'b0;
      res_data_out <= 16'h0000;
      sleep_q      <= 1'b0;
    end else begin
      tmr <= tmr + 32'h0000_0001;
      unique case (st)
        CV_IDLE: begin
          // Standby: only the timer runs between conversions.
          if (oneshot_in) begin
            st           <= CV_BUSY;
            conv_req_out <= 1'b1;
            os_busy_out  <= 1'b1;
            tmr          <= 32'h0000_0000;
          end else if (!sleep_in && (sleep_q || tmr >= period(rate_in) - 1)) begin
            st           <= CV_BUSY;
            conv_req_out <= 1'b1;
            tmr          <= 32'h0000_0000;
          end
        end
        CV_BUSY: begin
          if (oneshot_in) begin
            os_busy_out <= 1'b1;
          end else if (sleep_in && !os_busy_out) begin
            st           <= CV_IDLE;
            conv_req_out <= 1'b0;
          end else if (conv_done_in) begin
            st            <= CV_IDLE;
            conv_req_out  <= 1'b0;
            os_busy_out   <= 1'b0;
            res_valid_out <= 1'b1;
            res_data_out  <= conv_data_in;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hdl/tsr_top.sv ----
// Purpose: Register file, link crossing and alert logic of the sensor.
// Assumes: Link bytes arrive on link_clk_in already deframed.
// Notes:   Every link command is one toggle handshake into the core.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_top
  import tsr_pkg::*;
#(
  parameter int CLK_KHZ  = `TSR_CLK_KHZ,
  parameter int PER0_CYC = `TSR_RATE0_MS * CLK_KHZ,
  parameter int PER1_CYC = `TSR_RATE1_MS * CLK_KHZ,
  parameter int PER2_CYC = `TSR_RATE2_MS * CLK_KHZ,
  parameter int PER3_CYC = `TSR_RATE3_MS * CLK_KHZ
) (
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        link_clk_in,
  input  wire logic        link_start_in,
  input  wire logic        link_byte_valid_in,
  input  wire logic [7:0]  link_byte_in,
  input  wire logic        link_read_in,
  output logic [7:0]       link_byte_out,
  output logic             link_busy_out,
  input  wire logic        conv_done_in,
  input  wire logic [15:0] conv_data_in,
  output logic             conv_req_out,
  output logic             alert_out
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        l_rst_q1;
  logic        l_rst_q2;
  logic        l_req_tgl;
  tsr_cmd_t    l_cmd;
  logic [15:0] l_data;
  logic [1:0]  l_wcnt;
  logic [7:0]  l_msb;
  logic [7:0]  l_lsb;
  logic        l_rhalf;
  logic        l_rd_wait;
  logic        l_ack_q1;
  logic        l_ack_q2;
  logic        l_ack_seen;
  logic        c_req_q1;
  logic        c_req_q2;
  logic        c_req_q3;
  logic        c_ack_tgl;
  logic [15:0] c_rd_word;
  logic        cmd_go;
  logic [1:0]  ptr;
  logic [15:0] measured_temperature;
  logic [15:0] lower_limit;
  logic [15:0] upper_limit;
  logic [1:0]  rate_select;
  logic        sleep_select;
  logic        latch_mode_select;
  logic        alert_polarity;
  logic [1:0]  fault_count_select;
  logic        alert_flag;
  logic        os_go;
  logic        os_busy;
  logic        res_valid;
  logic [15:0] res_data;
  logic        over_state;
  logic [1:0]  fault_run;
  logic        evt_act;
  logic        evt_set;
  logic        evt_clr;
  logic        qual;
  logic [15:0] setup_word;
  logic        wr_setup;

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  // Reset reaches the link clock through two flops.
  always_ff @(posedge link_clk_in) begin
    l_rst_q1 <= resetn_in;
    l_rst_q2 <= l_rst_q1;
  end

  // The core answer toggle crosses as a level through two flops.
  always_ff @(posedge link_clk_in) begin
    l_ack_q1 <= c_ack_tgl;
    l_ack_q2 <= l_ack_q1;
  end

  // Byte assembly: pointer byte, then the word high byte before low byte.
  // While busy the link ignores new bytes, so the host must watch busy.
  always_ff @(posedge link_clk_in) begin
    if (!l_rst_q2) begin
      l_req_tgl     <= 1'b0;
      l_cmd         <= CMD_PTR;
      l_data        <= 16'h0000;
      l_wcnt        <= 2'h0;
      l_msb         <= 8'h00;
      l_lsb         <= 8'h00;
      l_rhalf       <= 1'b0;
      l_rd_wait     <= 1'b0;
      l_ack_seen    <= 1'b0;
      link_busy_out <= 1'b0;
      link_byte_out <= 8'h00;
    end else if (link_busy_out) begin
      if (l_ack_q2 != l_ack_seen) begin
        // The core word has been stable since its toggle moved.
        l_ack_seen    <= l_ack_q2;
        link_busy_out <= 1'b0;
        if (l_rd_wait) begin
          l_rd_wait     <= 1'b0;
          l_rhalf       <= 1'b1;
          link_byte_out <= c_rd_word[15:8];
          l_lsb         <= c_rd_word[7:0];
        end
      end
    end else if (link_start_in) begin
      l_wcnt  <= 2'h0;
      l_rhalf <= 1'b0;
    end else if (link_byte_valid_in) begin
      unique case (l_wcnt)
        2'h0: begin
          l_cmd         <= CMD_PTR;
          l_data        <= {8'h00, link_byte_in};
          l_req_tgl     <= ~l_req_tgl;
          link_busy_out <= 1'b1;
          l_wcnt        <= 2'h1;
        end
        2'h1: begin
          l_msb  <= link_byte_in;
          l_wcnt <= 2'h2;
        end
        2'h2: begin
          l_cmd         <= CMD_WR;
          l_data        <= {l_msb, link_byte_in};
          l_req_tgl     <= ~l_req_tgl;
          link_busy_out <= 1'b1;
          l_wcnt        <= 2'h3;
        end
        2'h3: l_wcnt <= 2'h3;
      endcase
    end else if (link_read_in) begin
      if (l_rhalf) begin
        link_byte_out <= l_lsb;
        l_rhalf       <= 1'b0;
      end else begin
        l_cmd         <= CMD_RD;
        l_req_tgl     <= ~l_req_tgl;
        link_busy_out <= 1'b1;
        l_rd_wait     <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core side of the crossing
  // ----------------------------------------------------------------
  // Only the second flop reads the first; the edge uses the later two.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      c_req_q1 <= 1'b0;
      c_req_q2 <= 1'b0;
      c_req_q3 <= 1'b0;
    end else begin
      c_req_q1 <= l_req_tgl;
      c_req_q2 <= c_req_q1;
      c_req_q3 <= c_req_q2;
    end
  end

  assign cmd_go   = c_req_q2 ^ c_req_q3;
  assign wr_setup = cmd_go && l_cmd == CMD_WR && ptr == `TSR_PTR_SETUP;

  // Setup word as read; reserved bits are fixed here, never stored.
  assign setup_word = {os_busy, 2'h2, fault_count_select, alert_polarity,
                       latch_mode_select, sleep_select, rate_select,
                       alert_flag, 5'h00};

  // Answer each command and toggle back once the read word is settled.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      c_ack_tgl <= 1'b0;
      c_rd_word <= 16'h0000;
      ptr       <= `TSR_PTR_TEMP;
    end else if (cmd_go) begin
      c_ack_tgl <= ~c_ack_tgl;
      if (l_cmd == CMD_PTR) begin
        ptr <= l_data[1:0];
      end
      if (l_cmd == CMD_RD) begin
        unique case (ptr)
          `TSR_PTR_TEMP:  c_rd_word <= measured_temperature;
          `TSR_PTR_SETUP: c_rd_word <= setup_word;
          `TSR_PTR_LOWER: c_rd_word <= lower_limit;
          `TSR_PTR_UPPER: c_rd_word <= upper_limit;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // The temperature slot has no write path at all.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      lower_limit <= `TSR_LOWER_RST;
      upper_limit <= `TSR_UPPER_RST;
    end else if (cmd_go && l_cmd == CMD_WR) begin
      if (ptr == `TSR_PTR_LOWER) begin
        lower_limit <= {l_data[15:4], `TSR_LIM_ZERO};
      end
      if (ptr == `TSR_PTR_UPPER) begin
        upper_limit <= {l_data[15:4], `TSR_LIM_ZERO};
      end
    end
  end

  // Setup fields; one-shot starts only when the same write leaves sleep on.
  always_ff @(posedge core_clk_in) begin
    os_go <= 1'b0;
    if (!resetn_in) begin
      rate_select        <= `TSR_RATE_RST;
      sleep_select       <= 1'b0;
      latch_mode_select  <= 1'b0;
      alert_polarity     <= 1'b0;
      fault_count_select <= 2'h0;
    end else if (wr_setup) begin
      rate_select        <= l_data[`TSR_B_RATE];
      sleep_select       <= l_data[`TSR_B_SLEEP];
      latch_mode_select  <= l_data[`TSR_B_LATCH];
      alert_polarity     <= l_data[`TSR_B_POL];
      fault_count_select <= l_data[`TSR_B_FAULT];
      os_go <= l_data[`TSR_B_ONESHOT] && l_data[`TSR_B_SLEEP] && !os_busy;
    end
  end

  // ----------------------------------------------------------------
  // Conversion scheduler
  // ----------------------------------------------------------------
  // Slower entry to sleep and a longer first conversion are converter
  // properties; this logic only stops asking for results.
  tsr_conv_sched #(
    .PER0_CYC (PER0_CYC),
    .PER1_CYC (PER1_CYC),
    .PER2_CYC (PER2_CYC),
    .PER3_CYC (PER3_CYC)
  ) u_sched (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .sleep_in      (sleep_select),
    .rate_in       (rate_select),
    .oneshot_in    (os_go),
    .conv_done_in  (conv_done_in),
    .conv_data_in  (conv_data_in),
    .conv_req_out  (conv_req_out),
    .res_valid_out (res_valid),
    .res_data_out  (res_data),
    .os_busy_out   (os_busy)
  );

  // The reading only moves on a finished conversion.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      measured_temperature <= 16'h0000;
    end else if (res_valid) begin
      measured_temperature <= res_data;
    end
  end

  // ----------------------------------------------------------------
  // Fault filter and alert
  // ----------------------------------------------------------------
  // Normal state qualifies on reaching the upper limit, over state on
  // reaching the lower one; both compare as signed words.
  assign qual = over_state ? ($signed(res_data) <= $signed(lower_limit))
                           : ($signed(res_data) >= $signed(upper_limit));

  // A run must be unbroken; the field value plus one is its length.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      over_state <= 1'b0;
      fault_run  <= 2'h0;
    end else if (res_valid) begin
      if (!qual) begin
        fault_run <= 2'h0;
      end else if (fault_run >= fault_count_select) begin
        over_state <= ~over_state;
        fault_run  <= 2'h0;
      end else begin
        fault_run <= fault_run + 2'h1;
      end
    end
  end

  // Event alert: any state change raises it, a read or sleep drops it.
  // A change in the clearing cycle wins so no crossing is lost.
  // A run left longer than a newly lowered field still ends at once.
  assign evt_set = res_valid && qual && fault_run >= fault_count_select;
  assign evt_clr = (cmd_go && l_cmd == CMD_RD) ||
                   (wr_setup && l_data[`TSR_B_SLEEP]);

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      evt_act <= 1'b0;
    end else if (evt_set) begin
      evt_act <= 1'b1;
    end else if (evt_clr) begin
      evt_act <= 1'b0;
    end
  end

  // Flag and pin share one register stage so comparator mode keeps them
  // equal on every cycle.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      alert_flag <= 1'b1;
      alert_out  <= 1'b1;
    end else begin
      alert_flag <= over_state ~^ alert_polarity;
      alert_out  <= (latch_mode_select ? evt_act : over_state)
                    ~^ alert_polarity;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_wake;
    wr_setup && !l_data[`TSR_B_SLEEP] && sleep_select;
  endsequence

  sequence s_sleep_on;
    wr_setup && l_data[`TSR_B_SLEEP] && !l_data[`TSR_B_ONESHOT];
  endsequence

  ptr_update_a: assert property (
    cmd_go && l_cmd == CMD_PTR |=> ptr == $past(l_data[1:0]))
    else $error("pointer not taken from pointer byte");

  temp_ro_a: assert property (
    cmd_go && l_cmd == CMD_WR && ptr == `TSR_PTR_TEMP && !res_valid
    |=> $stable(measured_temperature))
    else $error("temperature changed by a write");

  temp_hold_a: assert property (
    !res_valid |=> $stable(measured_temperature))
    else $error("temperature moved without a result");

  rsvd_bits_a: assert property (
    cmd_go && l_cmd == CMD_RD && ptr == `TSR_PTR_SETUP
    |=> c_rd_word[4:0] == 5'h00 && c_rd_word[14:13] == 2'h2)
    else $error("reserved setup bits wrong");

  comp_mirror_a: assert property (
    !$past(latch_mode_select) |-> alert_out == alert_flag)
    else $error("flag differs from pin in comparator mode");

  sleep_halt_a: assert property (
    s_sleep_on |-> ##2 !conv_req_out)
    else $error("conversion not halted by sleep");

  wake_conv_a: assert property (
    s_wake ##1 !os_busy |-> ##[1:2] conv_req_out)
    else $error("no conversion after leaving sleep");

  os_clear_a: assert property (
    res_valid && $past(os_busy) |-> !os_busy ##1 !os_busy)
    else $error("one-shot bit not cleared after result");

  state_cause_a: assert property (
    $changed(over_state) |-> $past(res_valid) && $past(qual))
    else $error("alert state moved without a qualifying result");

  evt_clear_a: assert property (
    evt_clr && !evt_set |=> !evt_act)
    else $error("event alert not cleared");

  link_busy_a: assert property (
    @(posedge link_clk_in) disable iff (!l_rst_q2)
    link_busy_out && l_ack_q2 != l_ack_seen && l_rd_wait
    |=> !link_busy_out && l_rhalf)
    else $error("read word not presented high byte first");
endmodule
`default_nettype wire

// ---- dv/tsr_link_host.sv ----
// Purpose: Bus host model driving the deframed link side of the sensor block.
// Assumes: Link clock runs free; each command waits for busy to drop.
// Notes:   Idle data lines carry the inverse of the last byte sent.
`timescale 1ns/1ps
`default_nettype none
module tsr_link_host (
  input  wire logic       link_clk_in,
  input  wire logic [7:0] link_byte_in,
  input  wire logic       link_busy_in,
  output var logic        start_out,
  output var logic        valid_out,
  output var logic [7:0]  byte_out,
  output var logic        read_out,
  output var logic        stall_out
);
  // ----------------------------------------------------------------
  // Link strobes
  // ----------------------------------------------------------------
  // Everything starts quiet so the first edge after reset sees no request.
  initial begin
    start_out = 1'b0;
    valid_out = 1'b0;
    byte_out  = 8'hA5;
    read_out  = 1'b0;
    stall_out = 1'b0;
  end

  // Bytes sent while busy are dropped, so every strobe is followed by a wait here.
  task automatic idle();
    int n;
    n = 0;
    repeat (2) @(posedge link_clk_in);
    while (link_busy_in !== 1'b0 && n < 64) begin
      @(posedge link_clk_in);
      n++;
    end
    if (n >= 64) stall_out <= 1'b1;
  endtask

  // One strobe for one link cycle: kind 0 start, 1 byte, 2 read.
  task automatic pulse(input int kind, input logic [7:0] b);
    @(posedge link_clk_in);
    start_out <= (kind == 0);
    valid_out <= (kind == 1);
    read_out  <= (kind == 2);
    byte_out  <= b;
    @(posedge link_clk_in);
    start_out <= 1'b0;
    valid_out <= 1'b0;
    read_out  <= 1'b0;
    byte_out  <= ~b;
    idle();
  endtask

  // ----------------------------------------------------------------
  // Register transfers
  // ----------------------------------------------------------------
  // Pointer first, then the word high byte first.
  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d);
    pulse(0, 8'h00);
    pulse(1, ptr);
    pulse(1, d[15:8]);
    pulse(1, d[7:0]);
  endtask

  // The first read fetches the word; the second shows its low byte.
  task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d);
    pulse(0, 8'h00);
    pulse(1, ptr);
    pulse(2, 8'h00);
    #1;
    d[15:8] = link_byte_in;
    pulse(2, 8'h00);
    #1;
    d[7:0] = link_byte_in;
  endtask
endmodule
`default_nettype wire

// ---- dv/tsr_top_test.sv ----
// Purpose: Self-checking bench of the sensor register, rate and alert block.
// Assumes: tsr_link_host plays the bus host; the converter is modelled here.
// Notes:   Rate periods are shortened through the PERn_CYC parameters.
`timescale 1ns/1ps
`default_nettype none
module tsr_top_test;
  localparam int PER [4] = '{400, 100, 25, 12};
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        conv_done = 1'b0;
  logic        req_q = 1'b0;
  logic        hi;
  logic [15:0] conv_data = 16'h0000;
  logic [15:0] temp = 16'h1230;
  logic [15:0] rd;
  int          lat = 8;
  int          cnt = 0;
  int          gap;
  int          errors = 0;
  int          checks = 0;
  wire logic   conv_req, alert, busy, start, valid, rdp, stall;
  wire logic [7:0] b_out, b_in;

  tsr_top #(.PER0_CYC(PER[0]), .PER1_CYC(PER[1]), .PER2_CYC(PER[2]),
    .PER3_CYC(PER[3])) dut (.core_clk_in(core_clk), .resetn_in(resetn),
    .link_clk_in(link_clk), .link_start_in(start), .link_byte_valid_in(valid),
    .link_byte_in(b_in), .link_read_in(rdp), .link_byte_out(b_out),
    .link_busy_out(busy), .conv_done_in(conv_done), .conv_data_in(conv_data),
    .conv_req_out(conv_req), .alert_out(alert));
  tsr_link_host host (.link_clk_in(link_clk), .link_byte_in(b_out),
    .link_busy_in(busy), .start_out(start), .valid_out(valid), .byte_out(b_in),
    .read_out(rdp), .stall_out(stall));

  // ----------------------------------------------------------------
  // Clocks and converter
  // ----------------------------------------------------------------
  // Two free clocks with unrelated phase.
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #3;
    forever #15 link_clk = ~link_clk;
  end

  // Converter answers lat+1 cycles after a request; idle data is inverted.
  always @(posedge core_clk) begin
    req_q <= conv_req;
    if (resetn && conv_req && !conv_done && cnt < lat) cnt <= cnt + 1;
    else cnt <= 0;
    conv_done <= resetn && conv_req && !conv_done && cnt == lat;
    conv_data <= (cnt == lat) ? temp : ~temp;
  end

  // A hung link command counts as a mismatch and ends the run.
  always @(posedge stall) begin
    errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare, count and report a mismatch.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Bounded wait for a request rise or a converter answer.
  task automatic wait_ev(input bit on_req, output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (!(on_req ? (conv_req && !req_q) : conv_done) && k < 3000);
    if (k >= 3000) begin
      errors++;
      report_and_stop();
    end
  endtask

  // Wait n results, then let the filter and pin settle.
  task automatic convs(input int n);
    repeat (n) wait_ev(1'b0, gap);
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Reset is long enough for the link domain to see four edges as well.
  initial begin
    repeat (13) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1;
    check(16'(conv_req), 16'h0001);
    repeat (4) @(posedge link_clk);
    host.read_reg(8'hFD, rd);
    check(rd, 16'h40A0);
    host.read_reg(8'h02, rd);
    check(rd, 16'h2580);
    host.read_reg(8'h03, rd);
    check(rd, 16'h2800);
    host.read_reg(8'h00, rd);
    check(rd, 16'h1230);
    $display("test reset_values done");
    for (int r = 0; r < 4; r++) begin
      host.write_reg(8'h01, {8'h00, 2'(r), 6'h00});
      wait_ev(1'b1, gap);
      wait_ev(1'b1, gap);
      check(16'(gap >= PER[r] - 1 && gap <= PER[r] + 1), 16'h0001);
    end
    host.write_reg(8'h01, 16'h68FF);
    host.read_reg(8'h01, rd);
    check(rd, 16'h48E0);
    $display("test rates done");
    host.write_reg(8'h02, 16'h100F);
    host.write_reg(8'h03, 16'h2000);
    host.read_reg(8'h02, rd);
    check(rd, 16'h1000);
    temp = 16'h2100;
    convs(1);
    check(16'(alert), 16'h0001);
    temp = 16'h1800;
    convs(1);
    temp = 16'h2100;
    convs(1);
    check(16'(alert), 16'h0001);
    convs(1);
    check(16'(alert), 16'h0000);
    host.read_reg(8'h01, rd);
    check(rd, 16'h48C0);
    host.write_reg(8'h01, 16'h0CC0);
    repeat (4) @(posedge core_clk);
    #1;
    check(16'(alert), 16'h0001);
    host.read_reg(8'h01, rd);
    check(rd, 16'h4CE0);
    temp = 16'h0800;
    convs(1);
    check(16'(alert), 16'h0001);
    convs(1);
    check(16'(alert), 16'h0000);
    $display("test comparator done");
    host.write_reg(8'h01, 16'h02C0);
    temp = 16'h2100;
    convs(1);
    check(16'(alert), 16'h0000);
    host.read_reg(8'h00, rd);
    check(rd, 16'h2100);
    check(16'(alert), 16'h0001);
    convs(2);
    check(16'(alert), 16'h0001);
    temp = 16'h0800;
    convs(1);
    check(16'(alert), 16'h0000);
    host.write_reg(8'h01, 16'h03C0);
    repeat (4) @(posedge core_clk);
    #1;
    check(16'(alert), 16'h0001);
    check(16'(conv_req), 16'h0000);
    $display("test event done");
    temp = 16'h0900;
    host.write_reg(8'h00, 16'hFFFF);
    host.read_reg(8'h00, rd);
    check(rd, 16'h0800);
    lat = 300;
    host.write_reg(8'h01, 16'h83C0);
    host.read_reg(8'h01, rd);
    check(rd & 16'h8100, 16'h8100);
    convs(1);
    host.read_reg(8'h01, rd);
    check(rd & 16'h8100, 16'h0100);
    host.read_reg(8'h00, rd);
    check(rd, 16'h0900);
    hi = 1'b0;
    repeat (60) begin
      @(posedge core_clk);
      #1;
      hi = hi | conv_req;
    end
    check(16'(hi), 16'h0000);
    lat = 8;
    host.write_reg(8'h01, 16'h00C0);
    wait_ev(1'b1, gap);
    check(16'(gap <= 40), 16'h0001);
    $display("test sleep done");
    host.write_reg(8'h01, 16'h18C0);
    temp = 16'h2100;
    convs(3);
    check(16'(alert), 16'h0001);
    convs(1);
    check(16'(alert), 16'h0000);
    $display("test filter done");
    report_and_stop();
  end
endmodule
`default_nettype wire
